/* rtl/mcuba_core.sv */
// Purpose: fetch, decode and execute core for branches, page call/jump, add and byte and
// Assumes: program memory and data memory answer combinationally in the cycle the address is shown
// Notes:   each instruction occupies exactly 12 or 24 clocks from its opcode fetch
//
// Summary of operation
// [RQ1] indirect jump to accumulator plus data pointer: one byte, 24 periods.
// [RQ2] branch on accumulator zero or nonzero: two bytes, relative, 24 periods.
// [RQ3] all four compare-and-branch-unequal forms: three bytes, 24 periods.
// [RQ4] decrement-and-branch: register form two bytes, direct form three; 24 periods.
// [RQ5] page call pushes return address low byte first, pre-incrementing stack pointer.
// [RQ6] page call target: upper five pc bits, opcode bits 7-5, second byte.
// [RQ7] page call is two bytes, two cycles, pattern 10001, flags untouched.
// [RQ8] page jump replaces pc bits 10..0 after the pc advanced by two.
// [RQ9] add leaves sum in accumulator; carry from bit 7, nibble carry from bit 3.
// [RQ10] signed excess flag is carry out of bit 6 xor carry out of bit 7.
// [RQ11] add sources: bank register, direct, indirect, immediate; one cycle each.
// [RQ12] add with carry also adds carry flag; high nibble 0011.
// [RQ13] byte and stores bitwise and into destination, no flag changes.
// [RQ14] and on a port reads the output latch, not the pins.
// [RQ15] and opcodes under 0101; direct-immediate form is three bytes, two cycles.
// [RQ16] rrr picks one of eight registers of the selected bank.
// [RQ17] the i bit picks which pointer register gives the ram address.
// [RQ18] direct addresses 0-127 reach ram, 128-255 reach special registers.
// [RQ19] one machine cycle is twelve oscillator periods.
// [RQ20] operand bytes fetched in order; pc passes all before targets form.
`timescale 1ns/1ns
module mcuba_core
    import mcuba_pkg::*;
#(
    parameter int unsigned N_OSC = mcuba_pkg::OSC_PER_MCYC
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // program memory
    output logic [15:0]      prog_addr_o,
    input  wire logic [7:0]  prog_rdata_i,
    // internal data memory and special registers
    output logic [7:0]       data_addr_o,
    output logic             data_rd_o,
    output logic             data_wr_o,
    output logic [7:0]       data_wdata_o,
    input  wire logic [7:0]  data_rdata_i,
    output logic             data_sfr_o,
    output logic             port_latch_rd_o,
    // neighbouring core state
    input  wire logic [1:0]  bank_sel_i,
    input  wire logic [15:0] data_pointer_i,
    // status
    output logic [7:0]       acc_o,
    output logic             carry_o,
    output logic             nibble_carry_flag_o,
    output logic             signed_excess_flag_o,
    output logic [7:0]       stack_pointer_o,
    output logic             instr_start_o
);
    import mcuba_pkg::*;

    // the step sequence needs seven clocks and the period counter is five bits wide
    if (N_OSC < 8 || N_OSC > 15) begin : g_bad_osc
        $error("N_OSC must lie between 8 and 15");
    end

    localparam logic [4:0] LEN1 = 5'(N_OSC);
    localparam logic [4:0] LEN2 = 5'(2 * N_OSC);

    mcuba_regs_t q;
    mcuba_regs_t d;
    mcuba_dec_t  dq;
    mcuba_dec_t  dn;
    logic [3:0]  hi;
    logic [7:0]  rel;
    logic [15:0] tgt;
    logic [7:0]  src;
    logic [10:0] sum;
    logic [7:0]  lhs;
    logic [7:0]  rhs;
    logic [7:0]  dec;
    logic        is_call;
    logic        is_page;
    logic        is_add;
    logic        is_and;

    // ****************************************
    // decode and operand selection
    // ****************************************
    assign dq      = mcuba_decode(q.op);
    assign dn      = mcuba_decode(prog_rdata_i);
    assign hi      = q.op[7:4];
    assign is_call = (q.op[4:0] == LO_PG_CALL);
    assign is_page = is_call || (q.op[4:0] == LO_PG_JUMP);
    assign is_add  = dq.ok && !is_page && (hi == HI_ADD || hi == HI_ADD_WITH_CARRY);
    assign is_and  = dq.ok && !is_page && (hi == HI_AND);
    assign rel     = (dq.nb == 2'd2) ? q.b2 : q.b1;            // offset is always the last byte
    assign tgt     = q.pc + {{8{rel[7]}}, rel};                 // pc already past the instruction [RQ20]
    assign src     = (dq.rn || dq.ind || dq.dir) ? q.mv : q.b1;
    assign sum     = mcuba_add8(q.acc, src, q.op[4] & q.cy);   // carry in only for 0011 group [RQ12]
    assign lhs     = (dq.rn || dq.ind) ? q.mv : q.acc;
    assign rhs     = dq.dir ? q.mv : q.b1;
    assign dec     = q.mv - 8'h01;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d     = q;
        d.dwr = 1'b0;
        d.per = q.per + 5'd1;
        unique case (q.st)
            ST_OP: begin
                d.op    = prog_rdata_i;
                d.pc    = q.pc + 16'h0001;
                d.per   = 5'd1;
                d.indon = 1'b0;
                d.dsfr  = 1'b0;
                if (dn.ind) begin
                    d.daddr = {3'b000, bank_sel_i, 2'b00, prog_rdata_i[0]};   // pointer register [RQ17]
                end else begin
                    d.daddr = {3'b000, bank_sel_i, prog_rdata_i[2:0]};        // bank register [RQ16]
                end
                d.st = (dn.nb != 2'd0) ? ST_B1 : ST_MEM;
            end
            ST_B1: begin
                d.b1 = prog_rdata_i;
                d.pc = q.pc + 16'h0001;                                 // operand bytes in order [RQ20]
                if (dq.dir) begin
                    d.daddr = prog_rdata_i;
                    d.dsfr  = prog_rdata_i[7];                          // upper half is special registers [RQ18]
                end
                d.st = (dq.nb == 2'd2) ? ST_B2 : ST_MEM;
            end
            ST_B2: begin
                d.b2 = prog_rdata_i;
                d.pc = q.pc + 16'h0001;                                 // [RQ20]
                d.st = ST_MEM;
            end
            ST_MEM: begin
                if (dq.ind && !q.indon) begin
                    d.daddr = data_rdata_i;                             // pointer value gives ram address [RQ17]
                    d.indon = 1'b1;
                end else begin
                    d.mv = data_rdata_i;
                    d.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                d.st = ST_WAIT;
                if (is_call) begin
                    d.sp     = q.sp + 8'h01;                            // pre-increment, low byte first [RQ5]
                    d.daddr  = q.sp + 8'h01;
                    d.dwdata = q.pc[7:0];
                    d.dwr    = 1'b1;
                    d.dsfr   = 1'b0;
                    d.st     = ST_PUSH;
                end else if (is_page) begin
                    d.pc = {q.pc[15:11], q.op[7:5], q.b1};              // [RQ8]
                end else if (q.op == OP_JMP_IND) begin
                    d.pc = data_pointer_i + {8'h00, q.acc};             // [RQ1]
                end else if (q.op == OP_JZ || q.op == OP_JNZ) begin
                    if ((q.acc == 8'h00) == (q.op == OP_JZ)) begin
                        d.pc = tgt;                                     // [RQ2]
                    end
                end else if (dq.ok && hi == HI_CMP) begin
                    d.cy = (lhs < rhs);                                 // unsigned less-than into carry
                    if (lhs != rhs) begin
                        d.pc = tgt;                                     // [RQ3]
                    end
                end else if (dq.ok && hi == HI_DEC) begin
                    d.dwdata = dec;
                    d.dwr    = 1'b1;
                    if (dec != 8'h00) begin
                        d.pc = tgt;                                     // [RQ4]
                    end
                end else if (is_add) begin
                    d.cy  = sum[10];                                    // [RQ9]
                    d.ac  = sum[9];                                     // [RQ9]
                    d.ov  = sum[8];                                     // [RQ10]
                    d.acc = sum[7:0];                                   // [RQ11] [RQ12]
                end else if (is_and && dq.rmw) begin
                    d.dwdata = q.mv & ((q.op[3:0] == LO_DIR_IMM) ? q.b2 : q.acc);   // [RQ13] [RQ15]
                    d.dwr    = 1'b1;
                end else if (is_and) begin
                    d.acc = q.acc & src;                                // flags left alone [RQ13]
                end
            end
            ST_PUSH: begin
                d.sp     = q.sp + 8'h01;                                // second push, high byte [RQ5]
                d.daddr  = q.sp + 8'h01;
                d.dwdata = q.pc[15:8];
                d.dwr    = 1'b1;
                d.pc     = {q.pc[15:11], q.op[7:5], q.b1};              // stays in same 2K block [RQ6] [RQ7]
                d.st     = ST_WAIT;
            end
            ST_WAIT: begin
                if (q.per == ((dq.two ? LEN2 : LEN1) - 5'd1)) begin
                    d.st = ST_OP;                                       // 12 or 24 periods per instruction [RQ19]
                end
            end
            default: begin
                d.st = ST_OP;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q    <= '0;
            q.st <= ST_OP;
            q.pc <= PC_RST;
            q.sp <= SP_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prog_addr_o          = q.pc;
    assign data_addr_o          = q.daddr;
    assign data_rd_o            = (q.st == ST_MEM) && (dq.rn || dq.ind || dq.dir);
    assign data_wr_o            = q.dwr;
    assign data_wdata_o         = q.dwdata;
    assign data_sfr_o           = q.dsfr;
    assign port_latch_rd_o      = (q.st == ST_MEM) && is_and && dq.rmw && q.dsfr;   // latch not pins [RQ14]
    assign acc_o                = q.acc;
    assign carry_o              = q.cy;
    assign nibble_carry_flag_o  = q.ac;
    assign signed_excess_flag_o = q.ov;
    assign stack_pointer_o      = q.sp;
    assign instr_start_o        = (q.st == ST_OP);

    // ****************************************
    // checks
    // ****************************************
    logic [4:0] gap_q;
    logic       plen_q;
    logic       seen_q;

    // clocks between opcode fetches and length of the previous instruction
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gap_q  <= 5'd0;
            plen_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (q.st == ST_OP) begin
            gap_q  <= 5'd1;
            plen_q <= dn.two;
            seen_q <= 1'b1;
        end else begin
            gap_q  <= gap_q + 5'd1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    instr_length_a: assert property (q.st == ST_OP && seen_q |-> gap_q == (plen_q ? LEN2 : LEN1)) // [RQ19]
        else $error("instruction length is not 12 or 24 periods");
    call_push_order_a: assert property (q.st == ST_EXEC && is_call // [RQ5]
        |=> data_wr_o && data_wdata_o == $past(q.pc[7:0])
        ##1 data_wr_o && data_wdata_o == $past(q.pc[15:8], 2))
        else $error("page call return address pushed in wrong order");
    call_stack_step_a: assert property (q.st == ST_EXEC && is_call |-> ##2 q.sp == $past(q.sp, 2) + 8'h02) // [RQ5]
        else $error("stack pointer did not advance by two");
    page_target_a: assert property (q.st == ST_EXEC && is_page |-> ##[1:2] (q.st == ST_WAIT // [RQ6]
        && q.pc == {$past(q.pc[15:11]), q.op[7:5], q.b1}))
        else $error("page target wrong");
    add_sum_a: assert property (q.st == ST_EXEC && is_add |=> {q.cy, q.acc} == {1'b0, $past(q.acc)} // [RQ9]
        + {1'b0, $past(src)} + {8'h00, $past(q.op[4] & q.cy)})
        else $error("add result or carry wrong");
    add_excess_a: assert property (q.st == ST_EXEC && is_add |=> q.ov == ($past(q.acc[7]) == $past(src[7]) // [RQ10]
        && q.acc[7] != $past(q.acc[7])))
        else $error("signed excess flag wrong");
    and_flags_a: assert property (q.st == ST_EXEC && is_and |=> $stable({q.cy, q.ac, q.ov})) // [RQ13]
        else $error("byte and changed a flag");
    latch_read_a: assert property (q.st == ST_MEM && q.op[7:4] == HI_AND && data_addr_o[7] // [RQ14]
        && (q.op[3:0] == LO_DIR_ACC || q.op[3:0] == LO_DIR_IMM) |-> data_rd_o && port_latch_rd_o)
        else $error("read-modify-write and did not read the latch");
    zero_branch_a: assert property (q.st == ST_EXEC && q.op == OP_JZ && q.acc == 8'h00 // [RQ2]
        |=> q.pc == $past(tgt))
        else $error("zero branch did not take its target");
    sfr_map_a: assert property (data_sfr_o |-> data_addr_o[7]) // [RQ18]
        else $error("special register select outside the upper half");
    jump_indirect_a: assert property (q.st == ST_EXEC && q.op == OP_JMP_IND // [RQ1]
        |=> q.pc == $past(data_pointer_i) + {8'h00, $past(q.acc)})
        else $error("indirect jump target wrong");
    nonzero_branch_a: assert property (q.st == ST_EXEC && q.op == OP_JNZ && q.acc != 8'h00 // [RQ2]
        |=> q.pc == $past(q.pc) + {{8{$past(q.b1[7])}}, $past(q.b1)})
        else $error("nonzero branch did not take its target");
    dec_write_a: assert property (q.st == ST_EXEC && dq.ok && hi == HI_DEC // [RQ4]
        |=> data_wr_o && data_wdata_o == $past(q.mv) - 8'h01 && data_addr_o == $past(data_addr_o))
        else $error("decrement not written back");
    bank_reg_addr_a: assert property (q.st == ST_OP && dn.ok && dn.rn // [RQ16]
        |=> data_addr_o == {3'b000, $past(bank_sel_i), $past(prog_rdata_i[2:0])})
        else $error("bank register address wrong");

    call_seen_c: cover property (q.st == ST_PUSH);
    add_with_carry_seen_c: cover property (q.st == ST_EXEC && is_add && q.op[4] && q.cy);
    and_rmw_c: cover property (q.st == ST_EXEC && is_and && dq.rmw && dq.two);
    cmp_taken_c: cover property (q.st == ST_EXEC && dq.ok && hi == HI_CMP && lhs != rhs);
endmodule : mcuba_core

/* rtl/mcuba_pkg.sv */
// Purpose: constants, types and helper functions of the branch, add and and-logic execution core
// Assumes: ref_clk_i is the oscillator itself, so one oscillator period is one clock
// Notes:   opcode fields are kept as named nibbles so decode reads like the encoding
package mcuba_pkg;
    // ****************************************
    // timing and reset values
    // ****************************************
    localparam int unsigned OSC_PER_MCYC = 12;      // oscillator periods per machine cycle
    localparam logic [15:0] PC_RST       = 16'h0000;
    localparam logic [7:0]  SP_RST       = 8'h07;
    // ****************************************
    // opcode encodings
    // ****************************************
    localparam logic [7:0]  OP_JMP_IND   = 8'h73;
    localparam logic [7:0]  OP_JZ        = 8'h60;
    localparam logic [7:0]  OP_JNZ       = 8'h70;
    localparam logic [4:0]  LO_PG_CALL   = 5'h11;
    localparam logic [4:0]  LO_PG_JUMP   = 5'h01;
    localparam logic [3:0]  HI_ADD       = 4'h2;
    localparam logic [3:0]  HI_ADD_WITH_CARRY      = 4'h3;
    localparam logic [3:0]  HI_AND       = 4'h5;
    localparam logic [3:0]  HI_CMP       = 4'hB;
    localparam logic [3:0]  HI_DEC       = 4'hD;
    localparam logic [3:0]  LO_IMM       = 4'h4;
    localparam logic [3:0]  LO_DIR       = 4'h5;
    localparam logic [3:0]  LO_DIR_ACC   = 4'h2;
    localparam logic [3:0]  LO_DIR_IMM   = 4'h3;
    localparam logic [2:0]  LO_IND       = 3'h3;    // low nibble 011i

    typedef enum logic [2:0] {ST_OP, ST_B1, ST_B2, ST_MEM, ST_EXEC, ST_PUSH, ST_WAIT} mcuba_st_t;

    typedef struct packed {
        logic       ok;     // opcode handled by this core
        logic [1:0] nb;     // operand bytes after the opcode
        logic       two;    // two machine cycles
        logic       rn;     // bank register source
        logic       ind;    // indirect source
        logic       dir;    // direct source
        logic       rmw;    // direct destination, read-modify-write
    } mcuba_dec_t;

    typedef struct packed {
        mcuba_st_t   st;
        logic [4:0]  per;
        logic [15:0] pc;
        logic [7:0]  sp;
        logic [7:0]  acc;
        logic        cy;
        logic        ac;
        logic        ov;
        logic [7:0]  op;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [7:0]  mv;
        logic        indon;
        logic [7:0]  daddr;
        logic        dwr;
        logic [7:0]  dwdata;
        logic        dsfr;
    } mcuba_regs_t;

    // ****************************************
    // opcode decode
    // ****************************************
    function automatic mcuba_dec_t mcuba_decode(input logic [7:0] op);
        mcuba_dec_t d;
        logic [3:0] hi;
        logic [3:0] lo;
        d  = '0;
        hi = op[7:4];
        lo = op[3:0];
        // shared source field of the register/direct/indirect/immediate groups
        d.rn  = lo[3];
        d.ind = (lo[3:1] == LO_IND);
        d.dir = (lo == LO_DIR);
        if (op[4:0] == LO_PG_CALL || op[4:0] == LO_PG_JUMP) begin
            d     = '0;
            d.ok  = 1'b1;
            d.nb  = 2'd1;
            d.two = 1'b1;
        end else if (op == OP_JMP_IND || op == OP_JZ || op == OP_JNZ) begin
            d     = '0;
            d.ok  = 1'b1;
            d.nb  = (op == OP_JMP_IND) ? 2'd0 : 2'd1;
            d.two = 1'b1;
        end else if (hi == HI_CMP && lo >= LO_IMM) begin
            d.ok  = 1'b1;
            d.nb  = 2'd2;
            d.two = 1'b1;
        end else if (hi == HI_DEC && (lo[3] || lo == LO_DIR)) begin
            d.ok  = 1'b1;
            d.nb  = lo[3] ? 2'd1 : 2'd2;
            d.two = 1'b1;
        end else if ((hi == HI_ADD || hi == HI_ADD_WITH_CARRY || hi == HI_AND) && lo >= LO_IMM) begin
            d.ok  = 1'b1;
            d.nb  = (lo == LO_DIR || lo == LO_IMM) ? 2'd1 : 2'd0;
        end else if (hi == HI_AND && (lo == LO_DIR_ACC || lo == LO_DIR_IMM)) begin
            d     = '0;
            d.ok  = 1'b1;
            d.dir = 1'b1;
            d.rmw = 1'b1;
            d.nb  = (lo == LO_DIR_IMM) ? 2'd2 : 2'd1;
            d.two = (lo == LO_DIR_IMM);
        end else begin
            d = '0;
        end
        return d;
    endfunction : mcuba_decode

    // sum with carry out of bit 7, bit 3 and overflow: {cy, ac, ov, sum}
    function automatic logic [10:0] mcuba_add8(input logic [7:0] a, input logic [7:0] b, input logic c);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] l;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        l = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c};
        return {s[8], n[4], s[8] ^ l[7], s[7:0]};
    endfunction : mcuba_add8
endpackage : mcuba_pkg

/* tb/mcuba_mem.sv */
// Purpose: program memory and internal data memory seen by the execution core
// Assumes: both memories answer combinationally; writes land on the rising edge
// Notes:   special register reads without the latch strobe return the pins, modelled as the latch inverted
`timescale 1ns/1ns
module mcuba_mem (
    // clock
    input  wire logic        ref_clk_i,
    // program side
    input  wire logic [15:0] prog_addr_i,
    output logic [7:0]       prog_rdata_o,
    // data side
    input  wire logic [7:0]  data_addr_i,
    input  wire logic        data_rd_i,
    input  wire logic        data_wr_i,
    input  wire logic [7:0]  data_wdata_i,
    input  wire logic        data_sfr_i,
    input  wire logic        port_latch_rd_i,
    output logic [7:0]       data_rdata_o
);
    logic [7:0] prog [0:4095];
    logic [7:0] ram  [0:255];

    // ****************************************
    // read paths
    // ****************************************
    // released read bus shows the inverse so a stale value never passes
    always_comb begin
        prog_rdata_o = prog[prog_addr_i[11:0]];
        if (!data_rd_i || (data_sfr_i && !port_latch_rd_i)) begin
            data_rdata_o = ~ram[data_addr_i];
        end else begin
            data_rdata_o = ram[data_addr_i];
        end
    end

    // one byte stored per write strobe
    always @(posedge ref_clk_i) begin
        if (data_wr_i) begin
            ram[data_addr_i] <= data_wdata_i;
        end
    end
endmodule : mcuba_mem

/* tb/test_mcuba_core.sv */
// Purpose: self-checking run of branch, call, add and and instructions through the core
// Assumes: one instruction program, stepped and judged at each opcode fetch
// Notes:   inputs change on the falling edge; bank 0, then bank 1 for the closing block
`timescale 1ns/1ns
module test_mcuba_core;
    import mcuba_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [1:0]  bank_sel_i = 2'h0;
    logic [15:0] data_pointer_i = 16'h0A00;
    logic [15:0] prog_addr_o;
    logic [7:0]  prog_rdata_i, data_addr_o, data_wdata_o, data_rdata_i, acc_o, stack_pointer_o;
    logic        data_rd_o, data_wr_o, data_sfr_o, port_latch_rd_o, carry_o;
    logic        nibble_carry_flag_o, signed_excess_flag_o, instr_start_o;
    int          bad_count = 0;
    int          n_compared = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    mcuba_core #(.N_OSC(12)) u_mcuba_core (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .prog_addr_o(prog_addr_o), .prog_rdata_i(prog_rdata_i),
        .data_addr_o(data_addr_o), .data_rd_o(data_rd_o), .data_wr_o(data_wr_o),
        .data_wdata_o(data_wdata_o), .data_rdata_i(data_rdata_i), .data_sfr_o(data_sfr_o),
        .port_latch_rd_o(port_latch_rd_o), .bank_sel_i(bank_sel_i), .data_pointer_i(data_pointer_i),
        .acc_o(acc_o), .carry_o(carry_o), .nibble_carry_flag_o(nibble_carry_flag_o),
        .signed_excess_flag_o(signed_excess_flag_o), .stack_pointer_o(stack_pointer_o),
        .instr_start_o(instr_start_o));

    mcuba_mem u_mcuba_mem (
        .ref_clk_i(ref_clk_i), .prog_addr_i(prog_addr_o), .prog_rdata_o(prog_rdata_i),
        .data_addr_i(data_addr_o), .data_rd_i(data_rd_o), .data_wr_i(data_wr_o),
        .data_wdata_i(data_wdata_o), .data_sfr_i(data_sfr_o), .port_latch_rd_i(port_latch_rd_o),
        .data_rdata_o(data_rdata_i));

    // ****************************************
    // helpers
    // ****************************************
    // compare and count, report at once on a difference
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // place n program bytes taken from the top of v
    task automatic ld(input logic [11:0] a, input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            u_mcuba_mem.prog[a + 12'(i)] = v[63 - 8 * i -: 8];
        end
    endtask : ld

    // one instruction: fetch address, length in clocks, then accumulator and {cy, ac, ov}
    task automatic step(input logic [15:0] pc, input int len, input logic [7:0] acc, input logic [2:0] fl);
        int n;
        n = 0;
        while (instr_start_o !== 1'b1 && n < 40) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n < 40) begin
            chk(prog_addr_o, pc);
            n = 0;
            do begin
                @(negedge ref_clk_i);
                n++;
            end while (instr_start_o !== 1'b1 && n < 40);
        end
        if (n >= 40) begin
            bad_count++;
            complete_run();
        end else begin
            chk(16'(n), 16'(len));
            chk({8'h00, acc_o}, {8'h00, acc});
            chk({13'h0, carry_o, nibble_carry_flag_o, signed_excess_flag_o}, {13'h0, fl});
        end
    endtask : step

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 4096; i++) u_mcuba_mem.prog[i] = 8'h00;
        for (int i = 0; i < 256; i++) u_mcuba_mem.ram[i] = 8'h00;
        ld(12'h000, 64'h24C3_2854_F535_2026, 8);
        ld(12'h008, 64'h5390_3C52_21E1_FE00, 7);
        ld(12'h7FE, 64'h3140_0000_0000_0000, 2);
        ld(12'h940, 64'h6005_0000_0000_0000, 2);
        ld(12'h947, 64'h7005_B400_03B8_1002, 8);
        ld(12'h951, 64'hD9FE_D522_FD73_0000, 6);
        ld(12'hA00, 64'h00B5_2001_00B6_AA00, 8);
        ld(12'hA08, 64'h2A25_0A5A_6005_7002, 8);
        u_mcuba_mem.ram[8'h00] = 8'hAA;
        u_mcuba_mem.ram[8'h01] = 8'h02;
        u_mcuba_mem.ram[8'h20] = 8'h1A;
        u_mcuba_mem.ram[8'h21] = 8'h5A;
        u_mcuba_mem.ram[8'h22] = 8'h01;
        u_mcuba_mem.ram[8'h90] = 8'hF7;
        u_mcuba_mem.ram[8'hAA] = 8'h80;
        u_mcuba_mem.ram[8'h0A] = 8'h3B;
        repeat (8) @(negedge ref_clk_i);
        chk({8'h00, stack_pointer_o}, {8'h00, SP_RST});
        rst_i = 1'b0;
        // add through every source mode, and with immediate source and both direct destination forms
        step(16'h0000, 12, 8'hC3, 3'h0);
        step(16'h0002, 12, 8'h6D, 3'h5);
        step(16'h0003, 12, 8'h65, 3'h5);
        step(16'h0005, 12, 8'h80, 3'h3);
        step(16'h0007, 12, 8'h00, 3'h5);
        step(16'h0008, 24, 8'h00, 3'h5);
        chk({8'h00, u_mcuba_mem.ram[8'h90]}, 16'h0034);
        step(16'h000B, 12, 8'h00, 3'h5);
        chk({8'h00, u_mcuba_mem.ram[8'h21]}, 16'h0000);
        // page jump then page call across a 2K boundary
        step(16'h000D, 24, 8'h00, 3'h5);
        step(16'h07FE, 24, 8'h00, 3'h5);
        chk({8'h00, stack_pointer_o}, 16'h0009);
        chk({u_mcuba_mem.ram[8'h09], u_mcuba_mem.ram[8'h08]}, 16'h0800);
        // conditional branches, taken and not taken
        step(16'h0940, 24, 8'h00, 3'h5);
        step(16'h0947, 24, 8'h00, 3'h5);
        step(16'h0949, 24, 8'h00, 3'h1);
        step(16'h094C, 24, 8'h00, 3'h1);
        step(16'h0951, 24, 8'h00, 3'h1);
        step(16'h0951, 24, 8'h00, 3'h1);
        chk({8'h00, u_mcuba_mem.ram[8'h01]}, 16'h0000);
        step(16'h0953, 24, 8'h00, 3'h1);
        chk({8'h00, u_mcuba_mem.ram[8'h22]}, 16'h0000);
        step(16'h0956, 24, 8'h00, 3'h1);
        step(16'h0A00, 12, 8'h00, 3'h1);
        step(16'h0A01, 24, 8'h00, 3'h5);
        step(16'h0A05, 24, 8'h00, 3'h5);
        chk(prog_addr_o, 16'h0A08);
        // bank 1 register sources, add direct, zero branch not taken, nonzero branch taken
        bank_sel_i = 2'h1;
        step(16'h0A08, 12, 8'h3B, 3'h0);
        step(16'h0A09, 12, 8'h76, 3'h2);
        step(16'h0A0B, 12, 8'h32, 3'h2);
        step(16'h0A0C, 24, 8'h32, 3'h2);
        step(16'h0A0E, 24, 8'h32, 3'h2);
        chk(prog_addr_o, 16'h0A12);
        complete_run();
    end
endmodule : test_mcuba_core
